// ### pkg/bbfc_pkg.sv
// shared constants and types for the boot block flash host controller
package bbfc_pkg;
    // ==========================================================
    // command codes placed on the low data byte
    localparam logic [7:0] BBFC_CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] BBFC_CMD_ERASE_GO    = 8'hD0;
    localparam logic [7:0] BBFC_CMD_PROG_SETUP  = 8'h40;
    localparam logic [7:0] BBFC_CMD_READ_ARRAY  = 8'hFF;
    // ==========================================================
    // status register bit positions
    localparam int BBFC_ST_READY   = 7;
    localparam int BBFC_ST_ESUSP   = 6;
    localparam int BBFC_ST_ERASE_E = 5;
    localparam int BBFC_ST_PROG_E  = 4;
    localparam int BBFC_ST_VPP_E   = 3;
    // ==========================================================
    // geometry
    localparam int          BBFC_ADDR_W    = 19;     // byte address
    localparam int          BBFC_DATA_W    = 16;
    localparam logic [18:0] BBFC_BOOT_SIZE = 19'h04000; // 16KB boot block
    localparam logic [15:0] BBFC_MASK_CMD  = 16'h00FF;
    localparam logic [15:0] BBFC_MASK_WORD = 16'hFFFF;
    localparam logic [15:0] BBFC_MASK_A_1  = 16'h8000; // dq15 carries a-1 in byte mode
    // ==========================================================
    // timing: times in ns, counts derived from the 40 ns clock
    localparam int BBFC_CLK_NS   = 40;
    localparam int BBFC_T_ACC_NS = 80;                // read access, least
    localparam int BBFC_T_WP_NS  = 50;                // write pulse, least
    localparam int BBFC_T_PD_NS  = 1000;              // power-down hold, least
    localparam int BBFC_SYNC_CYC = 2;
    localparam int BBFC_ACC_CYC  = (BBFC_T_ACC_NS + BBFC_CLK_NS - 1) / BBFC_CLK_NS;
    localparam int BBFC_WP_CYC   = (BBFC_T_WP_NS + BBFC_CLK_NS - 1) / BBFC_CLK_NS;
    localparam int BBFC_PD_CYC   = (BBFC_T_PD_NS + BBFC_CLK_NS - 1) / BBFC_CLK_NS;
    // ==========================================================
    // user operations
    typedef enum logic [2:0] {
        BBFC_OP_READ  = 3'h0,
        BBFC_OP_PROG  = 3'h1,
        BBFC_OP_ERASE = 3'h2,
        BBFC_OP_ID    = 3'h3,
        BBFC_OP_PDOWN = 3'h4
    } bbfc_op_t;
endpackage : bbfc_pkg

// ### pkg/bbfc_cyc_if.sv
// carrier between the operation sequencer and the pin cycle engine
`timescale 1ns/1ps
`default_nettype none
interface bbfc_cyc_if;
    logic        req;    // one-cycle pulse, only while engine idle
    logic        wr;     // 1 write cycle, 0 read cycle
    logic [17:0] addr;   // word address pins
    logic [15:0] wdata;
    logic [15:0] oe_mask;
    logic        done;   // one-cycle pulse
    logic [15:0] rdata;
    modport seq (output req, output wr, output addr, output wdata, output oe_mask,
                 input done, input rdata);
    modport engine (input req, input wr, input addr, input wdata, input oe_mask,
                    output done, output rdata);
endinterface : bbfc_cyc_if
`default_nettype wire

// ### rtl/bbfc_cycle.sv
// pin cycle engine: one read or write bus cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module bbfc_cycle
    import bbfc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    bbfc_cyc_if.engine       cy,
    input  wire logic [15:0] dq_i,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic [17:0]      addr,
    output logic [15:0]      dq_o,
    output logic [15:0]      dq_oe
);
    typedef enum logic [2:0] {E_IDLE = 3'b001, E_ACT = 3'b010, E_REC = 3'b100} bbfc_est_t;
    localparam logic [3:0] WR_LOAD = 4'(BBFC_WP_CYC - 1);
    localparam logic [3:0] RD_LOAD = 4'(BBFC_ACC_CYC + BBFC_SYNC_CYC - 1);

    bbfc_est_t   st_q;
    logic [3:0]  cnt_q;
    logic [15:0] s1_q, s2_q;
    logic        wr_q;

    // ==========================================================
    // pin input synchroniser, the first stage feeds only the second
    always_ff @(posedge sys_clk)
    begin
        s1_q <= dq_i;
        s2_q <= s1_q;
    end

    // ==========================================================
    // cycle sequence; strobes rise together so ce and we agree on the latch edge
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q     <= E_IDLE;
            cnt_q    <= '0;
            wr_q     <= 1'b0;
            ce_n     <= 1'b1;
            oe_n     <= 1'b1;
            we_n     <= 1'b1;
            addr     <= '0;
            dq_o     <= '0;
            dq_oe    <= '0;
            cy.done  <= 1'b0;
            cy.rdata <= '0;
        end
        else
        begin
            cy.done <= 1'b0;
            case (st_q)
                E_IDLE:
                begin
                    if (cy.req)
                    begin
                        st_q  <= E_ACT;
                        wr_q  <= cy.wr;
                        ce_n  <= 1'b0;
                        we_n  <= ~cy.wr;
                        oe_n  <= cy.wr;           // reads: we high, ce and oe low
                        addr  <= cy.addr;
                        dq_o  <= cy.wdata;
                        dq_oe <= cy.oe_mask;
                        cnt_q <= cy.wr ? WR_LOAD : RD_LOAD;
                    end
                end
                E_ACT:
                begin
                    if (cnt_q == 4'h0)
                    begin
                        ce_n <= 1'b1;             // rising edge latches command or data
                        we_n <= 1'b1;
                        oe_n <= 1'b1;
                        if (!wr_q)
                            cy.rdata <= s2_q;
                        st_q <= E_REC;
                    end
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
                E_REC:
                begin
                    dq_oe   <= '0;                // data held one cycle past the latch edge
                    cy.done <= 1'b1;
                    st_q    <= E_IDLE;
                end
                default: st_q <= E_IDLE;
            endcase
        end
    end
endmodule : bbfc_cycle
`default_nettype wire

// ### rtl/bbfc_host.sv
// host-side controller driving a boot block flash through its pins
`timescale 1ns/1ps
`default_nettype none
// Operation
// - host holds boot unlock for the whole boot program or erase
// - host holds programming supply high during program and erase
// - program data cycle follows directly after setup code 40h
// - host issues read-array ffh after every program or erase
// - reads hold write enable high, chip and output enable low
module bbfc_host
    import bbfc_pkg::*;
#(
    parameter bit BOOT_TOP = 1'b1,       // boot block at top of address space
    parameter int PD_CYC   = BBFC_PD_CYC
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [2:0]  cmd_op,
    input  wire logic [18:0] cmd_addr,
    input  wire logic [15:0] cmd_data,
    input  wire logic        cmd_word,
    output logic             rsp_valid,
    output logic [15:0]      rsp_data,
    output logic [7:0]       rsp_status,
    output logic             rsp_error,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic [17:0]      addr,
    output logic [15:0]      dq_o,
    output logic [15:0]      dq_oe,
    input  wire logic [15:0] dq_i,
    output logic             byte_n,
    output logic             reset_powerdown_n,
    output logic             unlock_super_voltage,
    output logic             boot_unlock,
    output logic             vpp_high,
    output logic             id_super_voltage
);
    typedef enum logic [6:0] {
        S_IDLE    = 7'b0000001,
        S_SETUP   = 7'b0000010,
        S_SECOND  = 7'b0000100,
        S_POLL    = 7'b0001000,
        S_RESTORE = 7'b0010000,
        S_READ    = 7'b0100000,
        S_PD      = 7'b1000000
    } bbfc_st_t;

    bbfc_cyc_if cy ();

    bbfc_st_t    st_q;
    logic        req_q, wr_q;
    logic [17:0] caddr_q;
    logic [15:0] wdata_q, mask_q;
    logic [18:0] uaddr_q;
    logic [15:0] udata_q;
    logic        word_q, erase_q;
    logic [31:0] pd_cnt_q;

    assign cy.req     = req_q;
    assign cy.wr      = wr_q;
    assign cy.addr    = caddr_q;
    assign cy.wdata   = wdata_q;
    assign cy.oe_mask = mask_q;

    // ==========================================================
    // boot block decode and bus width placement
    wire [18:0] boot_lo    = BOOT_TOP ? (19'h7FFFF - BBFC_BOOT_SIZE + 19'h00001) : 19'h00000;
    wire        in_boot    = (cmd_addr >= boot_lo) &&
                             (cmd_addr <= boot_lo + BBFC_BOOT_SIZE - 19'h00001);
    wire        lsb_pin    = ~word_q & uaddr_q[0];   // a-1 rides on dq15 in byte mode
    wire [15:0] a1_mask    = word_q ? 16'h0000 : BBFC_MASK_A_1;
    wire [15:0] cmd_wdata  = {lsb_pin, 15'h0000};
    wire [15:0] arr_wdata  = word_q ? udata_q : {lsb_pin, 7'h00, udata_q[7:0]};
    wire [15:0] arr_mask   = word_q ? BBFC_MASK_WORD : (BBFC_MASK_CMD | BBFC_MASK_A_1);
    wire [15:0] cmd_mask   = BBFC_MASK_CMD | a1_mask;  // commands on low byte only
    wire        dev_ready  = cy.rdata[BBFC_ST_READY];
    wire        any_err    = cy.rdata[BBFC_ST_VPP_E] | cy.rdata[BBFC_ST_PROG_E] |
                             cy.rdata[BBFC_ST_ERASE_E];
    wire [2:0]  op         = cmd_op;

    bbfc_cycle u_cycle (
        .sys_clk (sys_clk),
        .rst     (rst),
        .cy      (cy.engine),
        .dq_i    (dq_i),
        .ce_n    (ce_n),
        .oe_n    (oe_n),
        .we_n    (we_n),
        .addr    (addr),
        .dq_o    (dq_o),
        .dq_oe   (dq_oe)
    );

    // ==========================================================
    // operation sequencer; busy device only ever sees status reads
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q                 <= S_IDLE;
            req_q                <= 1'b0;
            wr_q                 <= 1'b0;
            caddr_q              <= '0;
            wdata_q              <= '0;
            mask_q               <= '0;
            uaddr_q              <= '0;
            udata_q              <= '0;
            word_q               <= 1'b0;
            erase_q              <= 1'b0;
            pd_cnt_q             <= '0;
            cmd_ready            <= 1'b0;
            rsp_valid            <= 1'b0;
            rsp_data             <= '0;
            rsp_status           <= '0;
            rsp_error            <= 1'b0;
            byte_n               <= 1'b0;
            reset_powerdown_n    <= 1'b1;
            unlock_super_voltage <= 1'b0;
            boot_unlock          <= 1'b0;
            vpp_high             <= 1'b0;
            id_super_voltage     <= 1'b0;
        end
        else
        begin
            req_q     <= 1'b0;
            rsp_valid <= 1'b0;
            case (st_q)
                S_IDLE:
                begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready)
                    begin
                        cmd_ready <= 1'b0;
                        uaddr_q   <= cmd_addr;
                        udata_q   <= cmd_data;
                        word_q    <= cmd_word;
                        byte_n    <= cmd_word;
                        caddr_q   <= cmd_addr[18:1];
                        mask_q    <= cmd_word ? 16'h0000 : BBFC_MASK_A_1;
                        wdata_q   <= {~cmd_word & cmd_addr[0], 15'h0000};
                        erase_q   <= (op == BBFC_OP_ERASE);
                        if (op == BBFC_OP_PDOWN)
                        begin
                            reset_powerdown_n <= 1'b0;
                            pd_cnt_q          <= 32'(PD_CYC);
                            st_q              <= S_PD;
                        end
                        else if (op == BBFC_OP_PROG || op == BBFC_OP_ERASE)
                        begin
                            vpp_high    <= 1'b1;
                            boot_unlock <= in_boot;
                            wr_q        <= 1'b1;
                            req_q       <= 1'b1;
                            mask_q      <= BBFC_MASK_CMD | (cmd_word ? 16'h0000 : BBFC_MASK_A_1);
                            wdata_q[7:0] <= (op == BBFC_OP_ERASE) ? BBFC_CMD_ERASE_SETUP
                                                                   : BBFC_CMD_PROG_SETUP;
                            st_q        <= S_SETUP;
                        end
                        else
                        begin
                            id_super_voltage <= (op == BBFC_OP_ID);
                            wr_q             <= 1'b0;
                            req_q            <= 1'b1;
                            st_q             <= S_READ;
                        end
                    end
                end
                S_SETUP:
                begin
                    if (cy.done)
                    begin
                        // second cycle follows directly, no other cycle between
                        req_q <= 1'b1;
                        wr_q  <= 1'b1;
                        if (erase_q)
                        begin
                            wdata_q <= cmd_wdata | {8'h00, BBFC_CMD_ERASE_GO};
                            mask_q  <= cmd_mask;
                        end
                        else
                        begin
                            wdata_q <= arr_wdata;
                            mask_q  <= arr_mask;
                        end
                        st_q <= S_SECOND;
                    end
                end
                S_SECOND:
                begin
                    if (cy.done)
                    begin
                        // device now answers reads with status
                        req_q  <= 1'b1;
                        wr_q   <= 1'b0;
                        mask_q <= a1_mask;
                        st_q   <= S_POLL;
                    end
                end
                S_POLL:
                begin
                    if (cy.done)
                    begin
                        if (!dev_ready)
                            req_q <= 1'b1;                      // only status reads while busy
                        else
                        begin
                            rsp_status <= cy.rdata[7:0];
                            rsp_error  <= any_err;
                            req_q      <= 1'b1;
                            wr_q       <= 1'b1;
                            wdata_q    <= cmd_wdata | {8'h00, BBFC_CMD_READ_ARRAY};
                            mask_q     <= cmd_mask;
                            st_q       <= S_RESTORE;
                        end
                    end
                end
                S_RESTORE:
                begin
                    if (cy.done)
                    begin
                        vpp_high    <= 1'b0;
                        boot_unlock <= 1'b0;                    // held until completion
                        rsp_data    <= '0;
                        rsp_valid   <= 1'b1;
                        st_q        <= S_IDLE;
                    end
                end
                S_READ:
                begin
                    if (cy.done)
                    begin
                        // data is driven only while ce and oe are low
                        rsp_data         <= word_q ? cy.rdata : {8'h00, cy.rdata[7:0]};
                        rsp_error        <= 1'b0;
                        id_super_voltage <= 1'b0;
                        rsp_valid        <= 1'b1;
                        st_q             <= S_IDLE;
                    end
                end
                S_PD:
                begin
                    if (pd_cnt_q == 32'h0000_0000)
                    begin
                        reset_powerdown_n <= 1'b1;              // device wakes in array read
                        rsp_status        <= '0;
                        rsp_error         <= 1'b0;
                        rsp_valid         <= 1'b1;
                        st_q              <= S_IDLE;
                    end
                    else
                        pd_cnt_q <= pd_cnt_q - 32'h0000_0001;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // unlock super-voltage is not used; the unlock pin carries boot protection
    wire unused_ok = unlock_super_voltage & uaddr_q[18];
endmodule : bbfc_host
`default_nettype wire

// ### testbench/bbfc_host_checker.sv
// concurrent checks on the host controller flash pins and command port
`timescale 1ns/1ps
`default_nettype none
module bbfc_host_checker
    import bbfc_pkg::*;
#(
    parameter int PD_CYC = BBFC_PD_CYC
)
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input wire logic [2:0]  cmd_op,
    input wire logic        rsp_valid,
    input wire logic        ce_n,
    input wire logic        oe_n,
    input wire logic        we_n,
    input wire logic [15:0] dq_oe,
    input wire logic        byte_n,
    input wire logic        reset_powerdown_n,
    input wire logic        vpp_high,
    input wire logic        id_super_voltage
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // power-down length counter
    int pd_cnt_q;
    always_ff @(posedge sys_clk)
    begin
        if (rst || reset_powerdown_n)
            pd_cnt_q <= 0;
        else
            pd_cnt_q <= pd_cnt_q + 1;
    end
    // ==========================================================
    // pin relations and command port timing
    a_read_we_high: assert property (!oe_n |-> we_n && !ce_n)
        else $error("output enable low without a clean read");
    a_read_no_drive: assert property (!oe_n |-> (dq_oe & 16'h7FFF) == 16'h0000)
        else $error("data driven during a read");
    a_byte_lanes: assert property (!byte_n |-> (dq_oe & 16'h7F00) == 16'h0000)
        else $error("upper lanes driven in byte mode");
    a_write_vpp: assert property (!we_n |-> vpp_high && !ce_n && oe_n)
        else $error("write cycle without supply or select");
    a_we_pulse: assert property ($fell(we_n) |-> !we_n [*2] ##1 we_n)
        else $error("write pulse not two cycles");
    a_pd_hold: assert property ($rose(reset_powerdown_n) |-> pd_cnt_q >= PD_CYC)
        else $error("power-down released too early");
    a_id_no_write: assert property (id_super_voltage |-> we_n)
        else $error("write while id voltage applied");
    a_read_answer: assert property (cmd_valid && cmd_ready && cmd_op == BBFC_OP_READ
        |-> ##[8:9] rsp_valid)
        else $error("read answer not in time");
    a_ready_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
        else $error("second command taken while busy");
    c_prog: cover property (cmd_valid && cmd_ready && cmd_op == BBFC_OP_PROG);
    c_erase: cover property (cmd_valid && cmd_ready && cmd_op == BBFC_OP_ERASE);
    c_pdown: cover property ($rose(reset_powerdown_n));
endmodule : bbfc_host_checker
bind bbfc_host bbfc_host_checker #(.PD_CYC(PD_CYC)) u_chk (.sys_clk(sys_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .rsp_valid(rsp_valid),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_oe(dq_oe), .byte_n(byte_n),
    .reset_powerdown_n(reset_powerdown_n), .vpp_high(vpp_high),
    .id_super_voltage(id_super_voltage));
`default_nettype wire

// ### testbench/bbfc_flash_model.sv
// behavioural boot block flash answering the controller pins
`timescale 1ns/1ps
`default_nettype none
module bbfc_flash_model
    import bbfc_pkg::*;
#(
    parameter int         POLLS  = 2,
    parameter int         SPAN   = 8192,  // erase span of a non-boot block
    parameter logic [7:0] MFR_ID = 8'h5A, // arbitrary value
    parameter logic [7:0] DEV_ID = 8'hA5  // arbitrary value
)
(
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [17:0] addr,
    input  wire logic [15:0] dq_o,
    output logic      [15:0] dq_i,
    input  wire logic        byte_n,
    input  wire logic        reset_powerdown_n,
    input  wire logic        boot_unlock,
    input  wire logic        vpp_high,
    input  wire logic        id_super_voltage
);
    // ==========================================================
    // state; erased cells read as all ones
    logic [7:0]  mem [int];
    logic [7:0]  st = 8'h00;
    logic        stat_q = 1'b0;
    logic        pset = 1'b0;
    logic        eset = 1'b0;
    logic        wsel = 1'b0;
    int          busy = 0;
    logic [15:0] rd;
    logic [15:0] last = 16'h0000;
    logic [18:0] ba;
    assign ba = byte_n ? {addr, 1'b0} : {addr, dq_o[15]};
    function automatic logic [7:0] rb(input int a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction : rb
    // ==========================================================
    // write cycles: program, erase and commands
    task automatic wr_cycle();
        int  base;
        int  n;
        logic bad;
        bad = !vpp_high || (ba >= 19'h7C000 && !boot_unlock);
        base = (ba >= 19'h7C000) ? 32'h7C000 : int'(ba) & ~(SPAN - 1);
        n = (ba >= 19'h7C000) ? 16384 : SPAN;
        if (!vpp_high)
            st[BBFC_ST_VPP_E] = 1'b1;
        if (pset || eset)
        begin
            stat_q = 1'b1;
            busy = POLLS;
        end
        if (pset && bad)
            st[BBFC_ST_PROG_E] = 1'b1;
        else if (pset)
        begin
            mem[ba] = rb(ba) & dq_o[7:0];
            if (byte_n)
                mem[ba + 1] = rb(ba + 1) & dq_o[15:8];
        end
        else if (eset && (bad || dq_o[7:0] != BBFC_CMD_ERASE_GO))
            st[BBFC_ST_ERASE_E] = 1'b1;
        else if (eset)
            for (int i = 0; i < n; i++)
                mem.delete(base + i);
        else if (busy == 0 && dq_o[7:0] == BBFC_CMD_READ_ARRAY)
            stat_q = 1'b0;
        {pset, eset} = {!pset && !eset && (dq_o[7:0] == 8'h40 || dq_o[7:0] == 8'h10),
                        !pset && !eset && dq_o[7:0] == BBFC_CMD_ERASE_SETUP};
    endtask : wr_cycle
    // latch on whichever of ce or we rises first
    always @*
        if (!ce_n && !we_n && reset_powerdown_n)
            wsel = 1'b1;
    always @(posedge we_n or posedge ce_n)
        if (wsel)
        begin
            wsel = 1'b0;
            wr_cycle();
        end
    // each status read of a busy part counts down the remaining work
    always @(negedge oe_n)
        if (!ce_n && stat_q && busy > 0)
            busy = busy - 1;
    // deep power-down clears status and returns to array read
    always @(negedge reset_powerdown_n)
    begin
        st = 8'h00;
        stat_q = 1'b0;
        pset = 1'b0;
        eset = 1'b0;
        busy = 0;
    end
    // read path; released lines show the inverse of the last value
    always @*
    begin
        if (id_super_voltage)
            rd = {8'h00, addr[0] ? DEV_ID : MFR_ID};
        else if (stat_q)
            rd = {8'h00, busy == 0, st[6:0]};
        else
            rd = byte_n ? {rb(ba + 1), rb(ba)} : {~last[15:8], rb(ba)};
    end
    always @(posedge oe_n)
        last = dq_i;
    assign dq_i = (!ce_n && !oe_n && reset_powerdown_n) ? rd : ~last;
endmodule : bbfc_flash_model
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the boot block flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb
    import bbfc_pkg::*;
();
    logic sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_word = 1'b1;
    logic cmd_ready, rsp_valid, rsp_error, ce_n, oe_n, we_n, byte_n, rpd_n;
    logic usv, boot_unlock, vpp_high, id_sv;
    logic [2:0] cmd_op = 3'h0;
    logic [18:0] cmd_addr = 19'h00000;
    logic [15:0] cmd_data = 16'h0000, rsp_data, dq_o, dq_oe, dq_i;
    logic [7:0] rsp_status;
    logic [17:0] addr;
    int fails = 0, checked = 0;
    always #20 sys_clk = ~sys_clk;
    bbfc_host #(.BOOT_TOP(1'b1), .PD_CYC(2)) DUT (.sys_clk(sys_clk), .rst(rst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .cmd_word(cmd_word), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_status(rsp_status), .rsp_error(rsp_error), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .byte_n(byte_n),
        .reset_powerdown_n(rpd_n), .unlock_super_voltage(usv), .boot_unlock(boot_unlock),
        .vpp_high(vpp_high), .id_super_voltage(id_sv));
    bbfc_flash_model u_flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
        .dq_o(dq_o), .dq_i(dq_i), .byte_n(byte_n), .reset_powerdown_n(rpd_n),
        .boot_unlock(boot_unlock | usv), .vpp_high(vpp_high), .id_super_voltage(id_sv));
    // ==========================================================
    // shared tasks
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
            fails++;
        if (got !== exp)
            $display("BAD %0t data %h expected %h", $time, got, exp);
    endtask : chk_data
    task automatic chk_stat(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
            fails++;
        if (got !== exp)
            $display("BAD %0t status %h expected %h", $time, got, exp);
    endtask : chk_stat
    // request held until taken, then wait for the answer pulse
    task automatic run(input bbfc_op_t op, input logic [18:0] a, input logic [15:0] d,
                       input logic w);
        int n;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_word <= w;
        cmd_valid <= 1'b1;
        n = 0;
        do @(posedge sys_clk); while (cmd_ready !== 1'b1 && ++n < 200);
        cmd_valid <= 1'b0;
        do @(posedge sys_clk); while (rsp_valid !== 1'b1 && ++n < 3000);
        if (n >= 3000)
            chk_stat(8'hEE, 8'h00);
    endtask : run
    // ==========================================================
    // scenarios
    task automatic t_prog();
        run(BBFC_OP_PROG, 19'h01000, 16'h1234, 1'b1);
        chk_stat(rsp_status, 8'h80);
        run(BBFC_OP_PROG, 19'h01000, 16'hFF0F, 1'b1);
        chk_stat({7'h00, rsp_error}, 8'h00);
        run(BBFC_OP_READ, 19'h01000, 16'h0000, 1'b1);
        chk_data(rsp_data, 16'h1204);
        run(BBFC_OP_PROG, 19'h7C010, 16'hA55A, 1'b1);
        run(BBFC_OP_READ, 19'h7C010, 16'h0000, 1'b1);
        chk_data(rsp_data, 16'hA55A);
        $display("test program done");
    endtask : t_prog
    task automatic t_erase();
        run(BBFC_OP_PROG, 19'h20000, 16'h0000, 1'b1);
        run(BBFC_OP_ERASE, 19'h20000, 16'h0000, 1'b1);
        chk_stat(rsp_status, 8'h80);
        run(BBFC_OP_READ, 19'h20000, 16'h0000, 1'b1);
        chk_data(rsp_data, 16'hFFFF);
        run(BBFC_OP_READ, 19'h01000, 16'h0000, 1'b1);
        chk_data(rsp_data, 16'h1204);
        $display("test erase done");
    endtask : t_erase
    task automatic t_id_byte();
        run(BBFC_OP_ID, 19'h00000, 16'h0000, 1'b1);
        chk_stat(rsp_data[7:0], 8'h5A);
        run(BBFC_OP_ID, 19'h00002, 16'h0000, 1'b1);
        chk_stat(rsp_data[7:0], 8'hA5);
        run(BBFC_OP_PROG, 19'h03001, 16'h003C, 1'b0);
        run(BBFC_OP_READ, 19'h03001, 16'h0000, 1'b0);
        chk_stat(rsp_data[7:0], 8'h3C);
        run(BBFC_OP_READ, 19'h03000, 16'h0000, 1'b1);
        chk_data(rsp_data, 16'h3CFF);
        $display("test id and byte done");
    endtask : t_id_byte
    task automatic t_pdown();
        run(BBFC_OP_PDOWN, 19'h00000, 16'h0000, 1'b1);
        chk_stat(rsp_status, 8'h00);
        run(BBFC_OP_READ, 19'h01000, 16'h0000, 1'b1);
        chk_data(rsp_data, 16'h1204);
        $display("test power-down done");
    endtask : t_pdown
    // ==========================================================
    // main sequence and watchdog
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        t_prog();
        t_erase();
        t_id_byte();
        t_pdown();
        summarize();
    end
    initial
    begin
        #2000000;
        fails++;
        summarize();
    end
endmodule : tb
`default_nettype wire
